// ---- rhp_pkg.sv ----
// Shared constants and carrier types for the root hub port block
package rhp_pkg;

	localparam int unsigned NPORTS = 2;

	// Register byte offsets
	localparam logic [7:0] PORT0_OFS = 8'h00;
	localparam logic [7:0] CFG_OFS   = 8'h08;
	localparam logic [7:0] ISTAT_OFS = 8'h0c;
	localparam logic [7:0] IMASK_OFS = 8'h10;

	// Port state register bit positions
	localparam int unsigned BIT_ATTACH     = 0;
	localparam int unsigned BIT_RESET      = 4;
	localparam int unsigned BIT_SUPPLY     = 8;
	localparam int unsigned BIT_SLOW       = 9;
	localparam int unsigned BIT_ATTACH_CHG = 16;
	localparam int unsigned BIT_DONE_CHG   = 20;
	localparam logic [31:0] PORT_RD_MASK   = 32'h00110311;

	// Configuration register bit positions
	localparam int unsigned CFG_SCHEME    = 0;
	localparam int unsigned CFG_SELECT_LO = 1;
	localparam int unsigned CFG_FIXED_LO  = 3;
	localparam int unsigned CFG_ALL_ON    = 8;
	localparam int unsigned CFG_ALL_OFF   = 9;
	localparam int unsigned CFG_HUB_RESET = 10;
	localparam int unsigned CFG_W         = 5;
	localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

	// Interrupt status: two events per port
	localparam int unsigned EVT_W = 2 * NPORTS;
	localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 32'h0000000a;
	localparam int unsigned MS_NS         = 32'h000f4240;
	localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned RESET_TIME_MS = 32'h0000000a;
	localparam int unsigned TICK_W        = 4;
	// One extra tick covers the partial first millisecond
	localparam logic [TICK_W-1:0] RESET_TICKS = TICK_W'(RESET_TIME_MS + 1);

	// Pins of one downstream port
	typedef struct packed {
		logic attach;
		logic slow;
		logic overCur;
	} rhp_pins_t;

	// State of one downstream port
	typedef struct packed {
		logic              supply;
		logic              resetActive;
		logic              attachChg;
		logic              doneChg;
		logic              prevAttach;
		logic [TICK_W-1:0] ticks;
	} rhp_port_t;

	localparam rhp_port_t PORT_RESET = '0;

endpackage : rhp_pkg

// ---- rhp_root_hub_ports.sv ----
// Root hub downstream port power, reset and status logic with APB registers
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module rhp_root_hub_ports import rhp_pkg::*; #(
	parameter int unsigned MS_CYCLES_P      = MS_CYCLES,
	parameter bit          SWITCH_SUPPORTED = 1'b1
) (
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire rhp_pins_t [NPORTS-1:0]  portPins,
	output logic      [NPORTS-1:0]       supplyEn,
	output logic      [NPORTS-1:0]       resetDrive,
	output logic                         irq
);

	// Byte offset of a port state register
	function automatic logic [7:0] portOfs(input int unsigned idx);
		portOfs = PORT0_OFS + 8'(4 * idx);
	endfunction : portOfs

	// Read image of a port state register
	function automatic logic [31:0] portRead(input rhp_port_t p, input logic att, input logic slow);
		portRead                 = '0;
		portRead[BIT_ATTACH]     = att;
		portRead[BIT_RESET]      = p.resetActive;
		portRead[BIT_SUPPLY]     = SWITCH_SUPPORTED ? p.supply : 1'b1;
		portRead[BIT_SLOW]       = att & slow;
		portRead[BIT_ATTACH_CHG] = p.attachChg;
		portRead[BIT_DONE_CHG]   = p.doneChg;
	endfunction : portRead

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	rhp_pins_t [NPORTS-1:0] pinsS;
	logic                   msTick;
	rhp_port_t [NPORTS-1:0] port_r;
	rhp_port_t [NPORTS-1:0] port_nxt;
	logic      [NPORTS-1:0] attNow;
	logic      [NPORTS-1:0] portWr;
	logic      [EVT_W-1:0]  evt;
	logic      [CFG_W-1:0]  cfg_r;
	logic      [CFG_W-1:0]  cfg_nxt;
	logic      [EVT_W-1:0]  istat_r;
	logic      [EVT_W-1:0]  istat_nxt;
	logic      [EVT_W-1:0]  imask_r;
	logic      [EVT_W-1:0]  imask_nxt;
	logic                   hubRst_r;
	logic                   hubRst_nxt;
	logic                   irq_nxt;
	logic      [31:0]       prdata_nxt;
	logic                   pready_nxt;
	logic                   pslverr_nxt;
	logic                   setupPh;
	logic                   wrEn;
	logic                   rdEn;
	logic                   cfgWr;
	logic                   allOn;
	logic                   allOff;
	logic                   mapped;

	// Pins come from the device side, outside our clock
	rhp_sync #(
		.W ($bits(pinsS))
	) uSync (
		.clk    (clk),
		.resetn (resetn),
		.d      (portPins),
		.q      (pinsS)
	);

	// Millisecond time base for reset signaling
	rhp_tick #(
		.CYCLES (MS_CYCLES_P)
	) uTick (
		.clk    (clk),
		.resetn (resetn),
		.tick   (msTick)
	);

	// Bus phase decode; zero-wait slave, errors decided in setup
	always_comb begin
		setupPh = psel & ~penable;
		wrEn    = psel & penable & pready & pwrite & ~pslverr;
		rdEn    = psel & penable & pready & ~pwrite & ~pslverr;
		cfgWr   = wrEn & (paddr == CFG_OFS);
		allOn   = cfgWr & pwdata[CFG_ALL_ON];
		allOff  = cfgWr & pwdata[CFG_ALL_OFF];
		for (int i = 0; i < NPORTS; i++) begin
			portWr[i] = wrEn & (paddr == portOfs(i));
		end
	end

	// Per-port power, attach and reset behaviour
	always_comb begin
		port_nxt = port_r;
		evt      = '0;
		for (int i = 0; i < NPORTS; i++) begin
			logic perPort;
			logic onCmd;
			logic offCmd;
			logic rstCmd;
			logic attSet;
			logic doneSet;
			perPort = 1'b0;
			onCmd   = 1'b0;
			offCmd  = 1'b0;
			rstCmd  = 1'b0;
			attSet  = 1'b0;
			doneSet = 1'b0;
			// Attach is only seen while the port is powered
			attNow[i] = pinsS[i].attach & port_r[i].supply;
			// Which command pair steers this port
			perPort = cfg_r[CFG_SCHEME] & cfg_r[CFG_SELECT_LO + i];
			onCmd   = perPort ? (portWr[i] & pwdata[BIT_SUPPLY]) : allOn;
			offCmd  = perPort ? (portWr[i] & pwdata[BIT_SLOW]) : allOff;
			if (onCmd) begin
				port_nxt[i].supply = 1'b1;
			end
			if (offCmd) begin
				port_nxt[i].supply = 1'b0;
			end
			if (pinsS[i].overCur) begin
				port_nxt[i].supply = 1'b0;
			end
			if (!SWITCH_SUPPORTED) begin
				port_nxt[i].supply = 1'b1;
			end
			// Reset signaling runs on the millisecond enable
			rstCmd = portWr[i] & pwdata[BIT_RESET];
			if (rstCmd && attNow[i] && !port_r[i].resetActive) begin
				port_nxt[i].resetActive = 1'b1;
				port_nxt[i].ticks       = RESET_TICKS;
			end else if (port_r[i].resetActive && msTick) begin
				if (port_r[i].ticks == TICK_W'(1)) begin
					port_nxt[i].resetActive = 1'b0;
					doneSet                 = 1'b1;
				end else begin
					port_nxt[i].ticks = port_r[i].ticks - TICK_W'(1);
				end
			end
			// Empty or unpowered port cannot hold reset
			if (!attNow[i] || !port_nxt[i].supply) begin
				port_nxt[i].resetActive = 1'b0;
			end
			// Attach change sources
			if (cfg_r[CFG_FIXED_LO + i]) begin
				attSet = hubRst_r & attNow[i];
			end else begin
				attSet = attNow[i] != port_r[i].prevAttach;
			end
			attSet = attSet | (rstCmd & ~attNow[i]);
			port_nxt[i].prevAttach = attNow[i];
			// Clear first so a coincident set wins
			if (portWr[i] && pwdata[BIT_ATTACH_CHG]) begin
				port_nxt[i].attachChg = 1'b0;
			end
			if (portWr[i] && pwdata[BIT_DONE_CHG]) begin
				port_nxt[i].doneChg = 1'b0;
			end
			if (attSet) begin
				port_nxt[i].attachChg = 1'b1;
			end
			if (doneSet) begin
				port_nxt[i].doneChg = 1'b1;
			end
			evt[2 * i]     = attSet;
			evt[2 * i + 1] = doneSet;
		end
	end

	// Configuration, interrupt and bus answer next values
	always_comb begin
		cfg_nxt    = cfg_r;
		imask_nxt  = imask_r;
		hubRst_nxt = cfgWr & pwdata[CFG_HUB_RESET];
		if (cfgWr) begin
			cfg_nxt = pwdata[CFG_W-1:0];
		end
		if (wrEn && paddr == IMASK_OFS) begin
			imask_nxt = pwdata[EVT_W-1:0];
		end
		// Clear only what the read returned, so late events survive
		istat_nxt = istat_r;
		if (rdEn && paddr == ISTAT_OFS) begin
			istat_nxt = istat_r & ~prdata[EVT_W-1:0];
		end
		istat_nxt = istat_nxt | evt;
		irq_nxt   = |(istat_nxt & imask_nxt);
		// Read data captured in setup, presented in access
		mapped = (paddr == CFG_OFS) || (paddr == ISTAT_OFS) || (paddr == IMASK_OFS);
		prdata_nxt = prdata;
		for (int i = 0; i < NPORTS; i++) begin
			if (paddr == portOfs(i)) begin
				mapped     = 1'b1;
				prdata_nxt = portRead(port_r[i], attNow[i], pinsS[i].slow);
			end
		end
		unique case (paddr)
			CFG_OFS: begin
				prdata_nxt = {27'h0000000, cfg_r};
			end
			ISTAT_OFS: begin
				prdata_nxt = {28'h0000000, istat_r};
			end
			IMASK_OFS: begin
				prdata_nxt = {28'h0000000, imask_r};
			end
			default: begin
				if (!mapped) begin
					prdata_nxt = '0;
				end
			end
		endcase
		if (!setupPh) begin
			prdata_nxt = prdata;
		end
		pready_nxt  = setupPh;
		pslverr_nxt = setupPh & ~mapped;
	end

	// State registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			port_r     <= {NPORTS{PORT_RESET}};
			cfg_r      <= CFG_RESET;
			istat_r    <= EVT_RESET;
			imask_r    <= EVT_RESET;
			hubRst_r   <= 1'b0;
			irq        <= 1'b0;
			prdata     <= '0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			supplyEn   <= '0;
			resetDrive <= '0;
		end else begin
			port_r   <= port_nxt;
			cfg_r    <= cfg_nxt;
			istat_r  <= istat_nxt;
			imask_r  <= imask_nxt;
			hubRst_r <= hubRst_nxt;
			irq      <= irq_nxt;
			prdata   <= prdata_nxt;
			pready   <= pready_nxt;
			pslverr  <= pslverr_nxt;
			for (int i = 0; i < NPORTS; i++) begin
				supplyEn[i]   <= port_nxt[i].supply;
				resetDrive[i] <= port_nxt[i].resetActive;
			end
		end
	end

	// Per-port checks
	for (genvar g = 0; g < NPORTS; g++) begin : gChk
		logic portRd;
		assign portRd = rdEn && (paddr == portOfs(g));

		a_slow_bit_read: assert property (
			portRd |-> prdata[BIT_SLOW] == $past(pinsS[g].slow & attNow[g])
		) else $error("speed bit does not match attached device");

		a_reserved_zero_read: assert property (
			portRd |-> (prdata & ~PORT_RD_MASK) == 32'h00000000
		) else $error("reserved port bits read nonzero");

		a_supply_pin_match: assert property (
			portRd |-> prdata[BIT_SUPPLY] == (SWITCH_SUPPORTED ? $past(supplyEn[g]) : 1'b1)
		) else $error("supply bit differs from supply pin");

		a_overcur_drops_supply: assert property (
			pinsS[g].overCur && SWITCH_SUPPORTED |=> !port_r[g].supply ##1 !supplyEn[g]
		) else $error("overcurrent did not remove supply");

		a_port_off_clears: assert property (
			portWr[g] && pwdata[BIT_SLOW] && cfg_r[CFG_SCHEME] && cfg_r[CFG_SELECT_LO + g] && SWITCH_SUPPORTED
			|=> !port_r[g].supply
		) else $error("port off command ignored");

		a_global_ignores_port: assert property (
			portWr[g] && !cfg_r[CFG_SCHEME] && !cfgWr && !pinsS[g].overCur
			|=> port_r[g].supply == $past(port_r[g].supply)
		) else $error("port command changed supply in global scheme");

		a_unpowered_quiet: assert property (
			!port_r[g].supply |-> !port_r[g].resetActive && !resetDrive[g]
		) else $error("reset active on unpowered port");

		a_reset_start: assert property (
			portWr[g] && pwdata[BIT_RESET] && attNow[g] && pinsS[g].attach
			|=> port_r[g].resetActive ##1 resetDrive[g]
		) else $error("reset command did not start reset");

		a_reset_end_flag: assert property (
			$fell(port_r[g].resetActive) && attNow[g] |-> port_r[g].doneChg
		) else $error("reset ended without done change");

		a_empty_no_reset: assert property (
			!attNow[g] |=> !port_r[g].resetActive
		) else $error("reset held on empty port");

		a_empty_reset_flag: assert property (
			portWr[g] && pwdata[BIT_RESET] && !attNow[g] |=> port_r[g].attachChg && !port_r[g].resetActive
		) else $error("reset of empty port did not flag attach change");

		a_fixed_only_hubrst: assert property (
			$rose(port_r[g].attachChg) && $past(cfg_r[CFG_FIXED_LO + g])
			|-> $past(hubRst_r) || $past(portWr[g] && pwdata[BIT_RESET])
		) else $error("fixed-attach port changed outside hub reset");
	end

endmodule : rhp_root_hub_ports

// ---- rhp_root_hub_ports_bench.sv ----
// Self-checking bench for the root hub port block
`timescale 1ns/1ps
module rhp_root_hub_ports_bench import rhp_pkg::*; ;
	localparam int unsigned MSC = 10;
	logic                   clk, resetn, psel, penable, pwrite, pready, pslverr, irq, lastErr;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata;
	logic [NPORTS-1:0]      supplyEn, resetDrive, plugged, lowSpeed, fault;
	rhp_pins_t [NPORTS-1:0] portPins;
	int                     failCount, checks;

	rhp_root_hub_ports #(.MS_CYCLES_P(MSC)) u_rhp_root_hub_ports (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .portPins(portPins), .supplyEn(supplyEn), .resetDrive(resetDrive), .irq(irq));
	rhp_usb_device u_rhp_usb_device (.plugged(plugged), .lowSpeed(lowSpeed), .fault(fault),
		.supplyEn(supplyEn), .pins(portPins));

	// 100 MHz clock
	always #5 clk = ~clk;

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// One APB transfer; idle edge first so psel never toggles twice in a step
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// No assumed latency; only the watchdog ends a stuck wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(a, 1'b1, d, r);
	endtask : wr

	task rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] r;
		apb(a, 1'b0, 32'h0, r);
		check(r, exp, what);
	endtask : rdChk

	task waitClk(input int n);
		repeat (n) @(posedge clk);
	endtask : waitClk

	task conclude;
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	task resetState;
		rdChk(PORT0_OFS, 32'h0, "port0 after reset");
		rdChk(8'h20, 32'h0, "unmapped read");
		check({31'h0, lastErr}, 32'h1, "unmapped error");
	endtask : resetState

	task globalPower;
		wr(CFG_OFS, 32'h0);
		wr(PORT0_OFS, 32'h100);
		rdChk(PORT0_OFS, 32'h0, "port on in global");
		wr(CFG_OFS, 32'h100);
		rdChk(8'h04, 32'h100, "all on");
		check({30'h0, supplyEn}, 32'h3, "switch pins");
		wr(8'h04, 32'h200);
		rdChk(8'h04, 32'h100, "port off in global");
		wr(CFG_OFS, 32'h200);
		rdChk(PORT0_OFS, 32'h0, "all off");
	endtask : globalPower

	task perPort;
		wr(CFG_OFS, 32'h3);
		wr(PORT0_OFS, 32'h100);
		rdChk(PORT0_OFS, 32'h100, "port on");
		wr(8'h04, 32'h100);
		rdChk(8'h04, 32'h0, "unselected port on");
		wr(CFG_OFS, 32'h103);
		rdChk(8'h04, 32'h100, "all on unselected");
		wr(CFG_OFS, 32'h203);
		rdChk(PORT0_OFS, 32'h100, "all off selected");
		rdChk(8'h04, 32'h0, "all off unselected");
		wr(PORT0_OFS, 32'h0);
		rdChk(PORT0_OFS, 32'h100, "zero write");
		wr(PORT0_OFS, 32'h200);
		rdChk(PORT0_OFS, 32'h0, "port off");
		wr(PORT0_OFS, 32'h100);
	endtask : perPort

	task attachSpeed;
		plugged[0] <= 1'b1;
		lowSpeed[0] <= 1'b1;
		waitClk(6);
		rdChk(PORT0_OFS, 32'h00010301, "slow attach");
		wr(PORT0_OFS, 32'hffeefcee);
		rdChk(PORT0_OFS, 32'h00010301, "reserved write");
		wr(PORT0_OFS, 32'h00010000);
		lowSpeed[0] <= 1'b0;
		waitClk(4);
		rdChk(PORT0_OFS, 32'h101, "full speed");
	endtask : attachSpeed

	// Reset length is only bounded loosely: the first tick may be partial
	task portReset;
		int n;
		rdChk(ISTAT_OFS, 32'h1, "attach event");
		wr(IMASK_OFS, 32'h2);
		wr(PORT0_OFS, 32'h10);
		rdChk(PORT0_OFS, 32'h111, "reset active");
		check({31'h0, resetDrive[0]}, 32'h1, "reset driven");
		n = 0;
		while (resetDrive[0] === 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, n >= 9 * MSC && n <= 12 * MSC}, 32'h1, "reset length");
		rdChk(PORT0_OFS, 32'h00100101, "reset done");
		check({31'h0, irq}, 32'h1, "irq raised");
		rdChk(ISTAT_OFS, 32'h2, "done event");
		waitClk(2);
		check({31'h0, irq}, 32'h0, "irq cleared");
		wr(PORT0_OFS, 32'h0);
		rdChk(PORT0_OFS, 32'h00100101, "zero keeps done");
		wr(PORT0_OFS, 32'h00100000);
		rdChk(PORT0_OFS, 32'h101, "done cleared");
	endtask : portReset

	task emptyReset;
		wr(CFG_OFS, 32'h103);
		wr(8'h04, 32'h10);
		rdChk(8'h04, 32'h00010100, "empty reset");
		check({30'h0, resetDrive}, 32'h0, "no reset drive");
	endtask : emptyReset

	// Cutting power mid-reset must drop reset signaling at once
	task resetPowerOff;
		wr(PORT0_OFS, 32'h10);
		wr(PORT0_OFS, 32'h200);
		waitClk(1);
		check({31'h0, resetDrive[0]}, 32'h0, "reset dropped with power");
		rdChk(PORT0_OFS, 32'h00010000, "unpowered port state");
		wr(PORT0_OFS, 32'h00010100);
		waitClk(4);
	endtask : resetPowerOff

	task overCurrent;
		fault[0] <= 1'b1;
		waitClk(10);
		check({31'h0, supplyEn[0]}, 32'h0, "overcurrent switch");
		rdChk(PORT0_OFS, 32'h00010000, "overcurrent state");
		fault[0] <= 1'b0;
	endtask : overCurrent

	task fixedAttach;
		wr(CFG_OFS, 32'h11);
		wr(8'h04, 32'h00010000);
		plugged[1] <= 1'b1;
		waitClk(6);
		rdChk(8'h04, 32'h101, "fixed no change");
		wr(CFG_OFS, 32'h411);
		rdChk(8'h04, 32'h00010101, "hub reset announce");
	endtask : fixedAttach

	// Main sequence
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		{psel, penable, pwrite, lastErr} = '0;
		paddr = '0;
		pwdata = '0;
		{plugged, lowSpeed, fault} = '0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		resetState();
		globalPower();
		perPort();
		attachSpeed();
		portReset();
		emptyReset();
		resetPowerOff();
		overCurrent();
		fixedAttach();
		conclude();
	end

	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#200000;
		failCount++;
		conclude();
	end
endmodule : rhp_root_hub_ports_bench

// ---- rhp_sync.sv ----
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module rhp_sync import rhp_pkg::*; #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// First stage feeds only the second
	always_comb begin
		meta_nxt = d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= meta_nxt;
			q      <= q_nxt;
		end
	end

endmodule : rhp_sync

// ---- rhp_tick.sv ----
// Free-running divider giving a one-cycle millisecond enable
`timescale 1ns/1ps
module rhp_tick import rhp_pkg::*; #(
	parameter int unsigned CYCLES = MS_CYCLES
) (
	input  wire logic clk,
	input  wire logic resetn,
	output logic      tick
);

	localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         tick_nxt;

	// Wrap at the last count and pulse once
	always_comb begin
		if (cnt_r == LAST) begin
			cnt_nxt  = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt  = cnt_r + W'(1);
			tick_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end

endmodule : rhp_tick

// ---- rhp_usb_device.sv ----
// Behavioural USB devices on the two downstream ports
`timescale 1ns/1ps
module rhp_usb_device import rhp_pkg::*; (
	input  wire logic [NPORTS-1:0] plugged,
	input  wire logic [NPORTS-1:0] lowSpeed,
	input  wire logic [NPORTS-1:0] fault,
	input  wire logic [NPORTS-1:0] supplyEn,
	output rhp_pins_t [NPORTS-1:0] pins
);
	// Pull-up needs bus power, so an unpowered device looks absent
	always_comb begin
		for (int i = 0; i < NPORTS; i++) begin
			pins[i].attach  = plugged[i] & supplyEn[i];
			pins[i].slow    = plugged[i] & lowSpeed[i] & supplyEn[i];
			pins[i].overCur = fault[i];
		end
	end
endmodule : rhp_usb_device
